/* File: pkg/pcint_pkg.sv */
// Package for the pin change interrupt unit: port layout, reset values and carriers.
package pcint_pkg;

  // ==========================================================================
  // Port layout
  // ==========================================================================
  localparam int unsigned PORT_W  = 8;
  localparam int unsigned N_PORTS = 3;
  localparam int unsigned PORT_A  = 0;
  localparam int unsigned PORT_B  = 1;
  localparam int unsigned PORT_C  = 2;

  // Implemented pins per port (first port has six pins, second only the upper four).
  localparam logic [PORT_W-1:0] PORT_A_PINS = 8'h3f;
  localparam logic [PORT_W-1:0] PORT_B_PINS = 8'hf0;
  localparam logic [PORT_W-1:0] PORT_C_PINS = 8'hff;

  // Bit position of the master clear pin within the first port.
  localparam int unsigned CLEAR_PIN_BIT = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [PORT_W-1:0] ENABLE_RST = 8'h00;
  localparam logic [PORT_W-1:0] FLAG_RST   = 8'h00;
  localparam logic [1:0]        SYNC_RST   = 2'h0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef logic [PORT_W-1:0] pcint_byte_t;

  // Per-port edge enables.
  typedef struct packed {
    pcint_byte_t rise;
    pcint_byte_t fall;
  } pcint_edge_en_t;

  // Software write to one port's flag register.
  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    pcint_byte_t data;
  } pcint_flag_wr_t;

  // Package variant selecting which ports offer change detection.
  typedef enum logic [1:0] {
    PCINT_PKG_SMALL = 2'h1,
    PCINT_PKG_LARGE = 2'h2
  } pcint_variant_t;

endpackage : pcint_pkg

/* File: verilog/pcint_top.sv */
// Pin change interrupt unit: per-pin edge detection, sticky flags and summary request.
//
// How it works
// - Any combination of available pins may raise change interrupts.
// - Small variants watch ports A, C only.
// - Master clear pin loses detection when configured.
// - Interrupt request needs the master enable.
// - Detection and flags run without master enable.
// - Rising detector per pin, gated by enable.
// - Falling detector per pin, gated by enable.
// - Both enables give detection of both edges.
// - Enabled edge sets that pin's flag.
// - Summary request is OR of all flags.
// - Summary request bit is read-only.
// - Writing zero to a flag clears it.
// - Edge during flag write leaves flag set.
// - Change event wakes from sleep when enabled.
// - Sleep edges are recorded before wake completes.
module pcint_top
  import pcint_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire pcint_variant_t            variant,
  input  wire logic                      reset_pin_enable,
  input  wire logic                      low_voltage_program,
  input  wire logic [N_PORTS*PORT_W-1:0] pin_in,
  input  wire pcint_edge_en_t [N_PORTS-1:0] edge_en,
  input  wire logic                      change_irq_enable,
  input  wire logic                      sleeping,
  input  wire pcint_flag_wr_t            flag_wr,
  output logic [N_PORTS*PORT_W-1:0]      edge_seen_flag,
  output logic                           change_irq_summary,
  output logic                           change_irq,
  output logic                           wake_request
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // Pin availability
  // ==========================================================================
  logic                       clear_pin_lost;
  logic                       port_b_on;
  logic [N_PORTS*PORT_W-1:0]  avail;
  logic [PORT_W-1:0]          clear_pin_mask;

  assign clear_pin_lost = reset_pin_enable | low_voltage_program;
  assign port_b_on      = (variant == PCINT_PKG_LARGE);
  assign clear_pin_mask = clear_pin_lost ? ~(PORT_W'(1) << CLEAR_PIN_BIT) : '1;
  assign avail[PORT_A*PORT_W +: PORT_W] = PORT_A_PINS & clear_pin_mask;
  assign avail[PORT_B*PORT_W +: PORT_W] = port_b_on ? PORT_B_PINS : '0;
  assign avail[PORT_C*PORT_W +: PORT_W] = PORT_C_PINS;

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  logic [N_PORTS*PORT_W-1:0] meta_q;
  logic [N_PORTS*PORT_W-1:0] sync_q;
  logic [N_PORTS*PORT_W-1:0] prev_q;
  logic [N_PORTS*PORT_W-1:0] flag_q;
  logic [N_PORTS*PORT_W-1:0] flag_d;
  logic [N_PORTS*PORT_W-1:0] hit;

  // Two flops for the asynchronous pin, a third to hold the previous sample.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are ignored until the previous-sample flop holds a real pin sample.
  // A pin that is already high when reset lifts is thus not taken for a rising edge.
  logic [2:0] prime_q;
  logic       primed;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prime_q <= '0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  assign primed = prime_q[2];

  genvar gp;
  generate
    for (gp = 0; gp < N_PORTS; gp++) begin : g_port
      pcint_byte_t rise_hit;
      pcint_byte_t fall_hit;
      pcint_byte_t cur;
      pcint_byte_t old;
      pcint_byte_t wr_keep;
      logic        wr_here;

      assign cur      = sync_q[gp*PORT_W +: PORT_W];
      assign old      = prev_q[gp*PORT_W +: PORT_W];
      assign rise_hit = cur & ~old & edge_en[gp].rise;
      assign fall_hit = ~cur & old & edge_en[gp].fall;
      assign hit[gp*PORT_W +: PORT_W] =
        (rise_hit | fall_hit) & avail[gp*PORT_W +: PORT_W] & {PORT_W{primed}};
      assign wr_here  = flag_wr.valid && (flag_wr.port == 2'(gp));
      // A write keeps only the bits written as one; zeros clear.
      assign wr_keep  = wr_here ? flag_wr.data : '1;
      // Set wins over clear, and detection never stops for sleep.
      assign flag_d[gp*PORT_W +: PORT_W] =
        (flag_q[gp*PORT_W +: PORT_W] & wr_keep) | hit[gp*PORT_W +: PORT_W];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= {N_PORTS{FLAG_RST}};
    end else begin
      flag_q <= flag_d & avail;
    end
  end

  // ==========================================================================
  // Summary, interrupt and wake
  // ==========================================================================
  assign edge_seen_flag     = flag_q;
  assign change_irq_summary = |flag_q;
  assign change_irq         = change_irq_summary & change_irq_enable;
  assign wake_request       = sleeping & change_irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_summary_or;
    @(posedge clk) disable iff (!rst_n)
      $rose(change_irq_summary) |-> $past(hit) != '0;
  endproperty
  a_summary_or: assert property (p_summary_or)
    else $error("Summary request rose without a detected edge.");

  property p_irq_gated;
    @(posedge clk) disable iff (!rst_n)
      !change_irq_enable |-> !change_irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("Interrupt raised with master enable clear.");

  property p_flag_without_enable;
    @(posedge clk) disable iff (!rst_n)
      (!change_irq_enable && |hit) |=> change_irq_summary;
  endproperty
  a_flag_without_enable: assert property (p_flag_without_enable)
    else $error("Flag not set while master enable clear.");

  property p_rise_sets;
    @(posedge clk) disable iff (!rst_n)
      (primed && sync_q[0] && !prev_q[0] && edge_en[0].rise[0] && avail[0])
        |=> edge_seen_flag[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("Enabled rising edge did not set flag.");

  property p_fall_sets;
    @(posedge clk) disable iff (!rst_n)
      (primed && !sync_q[17] && prev_q[17] && edge_en[2].fall[1]) |=> edge_seen_flag[17];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("Enabled falling edge did not set flag.");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_n)
      (!edge_seen_flag[16] && !hit[16]) |=> !edge_seen_flag[16];
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("Flag set without enabled edge.");

  property p_clear_zero;
    @(posedge clk) disable iff (!rst_n)
      (flag_wr.valid && flag_wr.port == 2'(PORT_C) && !flag_wr.data[0] && !hit[16])
        |=> !edge_seen_flag[16];
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Writing zero did not clear flag.");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      (flag_wr.valid && hit != '0) |=> (edge_seen_flag & $past(hit)) == $past(hit);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Edge during flag write was lost.");

  property p_clear_pin_off;
    @(posedge clk) disable iff (!rst_n)
      $stable(clear_pin_lost) && clear_pin_lost && !edge_seen_flag[CLEAR_PIN_BIT]
        |=> !edge_seen_flag[CLEAR_PIN_BIT];
  endproperty
  a_clear_pin_off: assert property (p_clear_pin_off)
    else $error("Master clear pin raised a change flag.");

  property p_small_no_b;
    @(posedge clk) disable iff (!rst_n)
      variant != PCINT_PKG_LARGE |=> edge_seen_flag[PORT_B*PORT_W +: PORT_W] == '0;
  endproperty
  a_small_no_b: assert property (p_small_no_b)
    else $error("Second port flag set on small variant.");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && change_irq_enable && change_irq_summary) |-> wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("No wake on enabled change during sleep.");

  property p_pin_to_flag;
    @(posedge clk) disable iff (!rst_n)
      (primed && $rose(pin_in[21]) && edge_en[2].rise[5] ##1 edge_en[2].rise[5] [*3])
        |-> edge_seen_flag[21] || $past(flag_wr.valid);
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag)
    else $error("Pin edge not flagged three cycles later.");

  property p_flags_quiet;
    @(posedge clk) disable iff (!rst_n)
      !primed |-> edge_seen_flag == '0;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet)
    else $error("Flag set before the pin samples were primed.");

  property p_rise_off;
    @(posedge clk) disable iff (!rst_n)
      (sync_q[17] && !prev_q[17] && !edge_en[2].rise[1] && !edge_seen_flag[17])
        |=> !edge_seen_flag[17];
  endproperty
  a_rise_off: assert property (p_rise_off)
    else $error("Rising edge flagged with its enable clear.");

  property p_fall_off;
    @(posedge clk) disable iff (!rst_n)
      (!sync_q[21] && prev_q[21] && !edge_en[2].fall[5] && !edge_seen_flag[21])
        |=> !edge_seen_flag[21];
  endproperty
  a_fall_off: assert property (p_fall_off)
    else $error("Falling edge flagged with its enable clear.");

  property p_both_edges;
    @(posedge clk) disable iff (!rst_n)
      (primed && sync_q[0] != prev_q[0] && edge_en[0].rise[0] && edge_en[0].fall[0] && avail[0])
        |=> edge_seen_flag[0];
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("Edge missed with both enables set.");

  property p_summary_hold;
    @(posedge clk) disable iff (!rst_n)
      (change_irq_summary && !flag_wr.valid && $stable(avail)) |=> change_irq_summary;
  endproperty
  a_summary_hold: assert property (p_summary_hold)
    else $error("Summary request dropped without a flag write.");

  property p_other_port_keeps;
    @(posedge clk) disable iff (!rst_n)
      (flag_wr.valid && flag_wr.port != 2'(PORT_A) && edge_seen_flag[1]) |=> edge_seen_flag[1];
  endproperty
  a_other_port_keeps: assert property (p_other_port_keeps)
    else $error("Write to another port cleared a flag.");

  property p_bad_port;
    @(posedge clk) disable iff (!rst_n)
      (flag_wr.valid && flag_wr.port == 2'(N_PORTS) && hit == '0 && $stable(avail))
        |=> $stable(edge_seen_flag);
  endproperty
  a_bad_port: assert property (p_bad_port)
    else $error("Write to an absent port changed the flags.");

  property p_wake_only;
    @(posedge clk) disable iff (!rst_n)
      wake_request |-> sleeping && change_irq_enable && change_irq_summary;
  endproperty
  a_wake_only: assert property (p_wake_only)
    else $error("Wake raised without an enabled change.");

  property p_sleep_record;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && hit[16]) |=> edge_seen_flag[16];
  endproperty
  a_sleep_record: assert property (p_sleep_record)
    else $error("Edge during sleep was not recorded.");

  c_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(change_irq_summary));
  c_wake: cover property (@(posedge clk) disable iff (!rst_n) $rose(wake_request));
  c_set_wins: cover property (@(posedge clk) disable iff (!rst_n) flag_wr.valid && |hit);
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(change_irq_summary));
  c_sleep_edge: cover property (@(posedge clk) disable iff (!rst_n) sleeping && hit != '0);

endmodule // pcint_top

/* File: dv/pcint_pins.sv */
// Model of the external signals on the port pins.
module pcint_pins
  import pcint_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic [N_PORTS*PORT_W-1:0] level,
  output logic      [N_PORTS*PORT_W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins move at the falling edge after a new level is asked for.
  initial pin_in = '0;
  always @(negedge clk) begin
    pin_in <= level;
  end
endmodule // pcint_pins

/* File: dv/pcint_top_test.sv */
// Self-checking bench for the pin change interrupt unit.
module pcint_top_test;
  import pcint_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic                         clk, nrst, reset_pin_enable, low_voltage_program;
  logic                         change_irq_enable, sleeping;
  pcint_variant_t               variant;
  logic [N_PORTS*PORT_W-1:0]    level, pin_in, edge_seen_flag;
  pcint_edge_en_t [N_PORTS-1:0] edge_en;
  pcint_flag_wr_t               flag_wr;
  logic                         change_irq_summary, change_irq, wake_request;
  int                           n_fail = 0;
  int                           n_compared = 0;
  int                           n_cyc = 0;

  pcint_pins i_pins (.clk, .level, .pin_in);
  pcint_top i_dut (.clk, .nrst, .variant, .reset_pin_enable, .low_voltage_program,
    .pin_in, .edge_en, .change_irq_enable, .sleeping, .flag_wr, .edge_seen_flag,
    .change_irq_summary, .change_irq, .wake_request);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 2000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Moves the pins, waits past the synchroniser and compares the flags.
  task automatic step(input logic [23:0] lv, input logic [23:0] exp);
    level <= lv;
    cyc(5);
    chk({edge_seen_flag, change_irq_summary}, {exp, |exp});
  endtask

  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    flag_wr <= '{1'b1, p, d};
    cyc(1);
    flag_wr <= '0;
    cyc(1);
  endtask

  task automatic clean();
    edge_en <= '0;
    level <= '0;
    cyc(5);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h00);
    chk({edge_seen_flag, change_irq_summary}, '0);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_edges();
    edge_en[0] <= '{8'h01, 8'h01};
    edge_en[2] <= '{8'h01, 8'h02};
    step(24'h030001, 24'h010001);
    wr(2'h0, 8'h00);
    chk({edge_seen_flag, change_irq_summary}, {24'h010000, 1'b1});
    step(24'h000000, 24'h030001);
    clean();
  endtask

  task automatic t_master();
    edge_en[2] <= '{8'h01, 8'h00};
    sleeping <= 1'b1;
    step(24'h010000, 24'h010000);
    chk({22'h0, change_irq_summary, change_irq, wake_request}, 25'h4);
    change_irq_enable <= 1'b1;
    cyc(1);
    chk({23'h0, change_irq, wake_request}, 25'h3);
    sleeping <= 1'b0;
    cyc(1);
    chk({24'h0, wake_request}, 25'h0);
    clean();
  endtask

  task automatic t_clear();
    edge_en[0] <= '{8'h02, 8'h00};
    edge_en[2] <= '{8'h20, 8'h00};
    step(24'h200002, 24'h200002);
    wr(2'h2, 8'hdf);
    chk({edge_seen_flag, change_irq_summary}, 25'h5);
    wr(2'h3, 8'h00);
    chk({edge_seen_flag, change_irq_summary}, {24'h000002, 1'b1});
    wr(2'h0, 8'hfd);
    chk({edge_seen_flag, change_irq_summary}, 25'h0);
    clean();
  endtask

  // The write lands on the very edge at which the new pin edge is flagged.
  task automatic t_race();
    edge_en[2] <= '{8'h03, 8'h00};
    step(24'h010000, 24'h010000);
    level <= 24'h030000;
    cyc(3);
    wr(2'h2, 8'h00);
    chk({edge_seen_flag, change_irq_summary}, {24'h020000, 1'b1});
    clean();
  endtask

  task automatic t_avail();
    int         pin [6] = '{12, 12, 3, 3, 3, 6};
    logic [2:0] cfg [6] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h0, 3'h0};
    for (int i = 0; i < 6; i++) begin
      variant <= cfg[i][2] ? PCINT_PKG_SMALL : PCINT_PKG_LARGE;
      reset_pin_enable <= cfg[i][1];
      low_voltage_program <= cfg[i][0];
      edge_en <= {N_PORTS{16'hff00}};
      step(24'h1 << pin[i], (i == 1 || i == 4) ? 24'h1 << pin[i] : 24'h0);
      clean();
    end
  endtask

  initial begin
    nrst = 1'b0;
    variant = PCINT_PKG_LARGE;
    reset_pin_enable = 1'b0;
    low_voltage_program = 1'b0;
    change_irq_enable = 1'b0;
    sleeping = 1'b0;
    level = '0;
    edge_en = '0;
    flag_wr = '0;
    cyc(6);
    nrst <= 1'b1;
    cyc(3);
    chk({edge_seen_flag, change_irq_summary}, 25'h0);
    t_edges();
    t_master();
    t_clear();
    t_race();
    t_avail();
    wrap_up();
  end
endmodule // pcint_top_test
